// [common/mcsd_pkg.sv]
// mcsd_pkg: constants for the module chip select decoder.
// assumes nothing beyond a SystemVerilog package scope.
package mcsd_pkg;
	localparam int          ADDR_W        = 4;
	localparam int          ADDR_MSB      = 25;
	localparam int          ADDR_LSB      = 22;
	localparam logic [31:0] CS1_BASE      = 32'h0400_0000;
	localparam logic [31:0] CS3_BASE      = 32'h0C00_0000;
	localparam logic [3:0]  CODE_NAND     = 4'h0;
	localparam logic [3:0]  CODE_CLOCK    = 4'h5;
	localparam logic [3:0]  CODE_ETH      = 4'h6;
	localparam logic [3:0]  CODE_LB_ZERO  = 4'h0;
	localparam logic [3:0]  CODE_LB_TWO   = 4'h4;
	localparam logic [3:0]  CODE_LB_THREE = 4'h6;
	localparam logic [3:0]  CODE_DISK_PRI = 4'hC;
	localparam logic [3:0]  CODE_DISK_SEC = 4'h8;
	localparam logic [3:0]  MASK_DISK_SEC = 4'hE;
	localparam logic [8:0]  SEL_IDLE_N    = 9'h1FF;
	localparam logic [5:0]  PINS_IDLE     = 6'h3F;
endpackage

// [design/mcsd_sync.sv]
// mcsd_sync: two-flop synchroniser for a vector of pin inputs.
// assumes one clock; output used only by downstream logic.
`timescale 1ns/100ps
module mcsd_sync #(
	parameter int          W          = 6,
	parameter logic [5:0]  RESET_VAL  = 6'h3F
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			meta_q <= RESET_VAL[W-1:0];
			q      <= RESET_VAL[W-1:0];
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // mcsd_sync

// [design/mcsd_decoder.sv]
// mcsd_decoder: turns two static chip selects and four address bits into selects.
// assumes inputs arrive from the processor pins asynchronously to clk_sys.
//
// Notes on behaviour
// R1: selects depend only on selects one, three, address.
// R2: select one low: nand, clock, ethernet codes.
// R3: select three low: local bus zero/two/three codes.
// R4: select three low: local bus one always.
// R5: select three low, 1100: primary disk.
// R6: select three low, 1000/1001: secondary disk.
// R7: host reaches onboard selects at region one.
// R8: host reaches external selects at region three.
// R9: all selects active low, idle high otherwise.
`timescale 1ns/100ps
module mcsd_decoder (
	input  wire logic                         clk_sys,
	input  wire logic                         reset,
	input  wire logic                         cpu_static_select_one_n,
	input  wire logic                         cpu_static_select_three_n,
	input  wire logic [mcsd_pkg::ADDR_W-1:0]  upper_address_bits,
	output logic                              nand_select_n,
	output logic                              clock_chip_select_n,
	output logic                              ethernet_select_n,
	output logic                              local_bus_select_zero_n,
	output logic                              local_bus_select_one_n,
	output logic                              local_bus_select_two_n,
	output logic                              local_bus_select_three_n,
	output logic                              disk_primary_select_n,
	output logic                              disk_secondary_select_n
);
	localparam logic [mcsd_pkg::ADDR_W-1:0] MASK_ALL = '1;

	// pins are asynchronous, so sample through two flops; costs two cycles of latency
	logic [5:0] pins_s;

	mcsd_sync #(
		.W         (6),
		.RESET_VAL (mcsd_pkg::PINS_IDLE)
	) u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.d       ({cpu_static_select_one_n, cpu_static_select_three_n, upper_address_bits}),
		.q       (pins_s)
	);

	// address code under a mask; the secondary disk ignores the lowest bit
	function automatic logic code_hit(
		input logic                        region,
		input logic [mcsd_pkg::ADDR_W-1:0] addr_bits,
		input logic [mcsd_pkg::ADDR_W-1:0] code,
		input logic [mcsd_pkg::ADDR_W-1:0] mask
	);
		code_hit = region && ((addr_bits & mask) == code);
	endfunction

	wire                        one_n   = pins_s[5];
	wire                        three_n = pins_s[4];
	wire [mcsd_pkg::ADDR_W-1:0] addr    = pins_s[3:0];

	// both low at once is not a legal cycle: treat it as idle
	wire region_one   = !one_n && three_n; // [R1] [R7]
	wire region_three = one_n && !three_n; // [R1] [R8]

	// onboard peripherals behind select one
	wire hit_nand     = code_hit(region_one, addr, mcsd_pkg::CODE_NAND, MASK_ALL); // [R2]
	wire hit_clock    = code_hit(region_one, addr, mcsd_pkg::CODE_CLOCK, MASK_ALL); // [R2]
	wire hit_eth      = code_hit(region_one, addr, mcsd_pkg::CODE_ETH, MASK_ALL); // [R2]

	// external local bus and disks behind select three
	wire hit_lb_zero  = code_hit(region_three, addr, mcsd_pkg::CODE_LB_ZERO, MASK_ALL); // [R3]
	wire hit_lb_one   = region_three; // [R4]
	wire hit_lb_two   = code_hit(region_three, addr, mcsd_pkg::CODE_LB_TWO, MASK_ALL); // [R3]
	wire hit_lb_three = code_hit(region_three, addr, mcsd_pkg::CODE_LB_THREE, MASK_ALL); // [R3]
	wire hit_disk_pri = code_hit(region_three, addr, mcsd_pkg::CODE_DISK_PRI, MASK_ALL); // [R5]
	wire hit_disk_sec = code_hit(region_three, addr, mcsd_pkg::CODE_DISK_SEC, mcsd_pkg::MASK_DISK_SEC); // [R6]

	// selects are active low, so a miss leaves them high
	wire nand_n_d      = !hit_nand; // [R9]
	wire clock_n_d     = !hit_clock; // [R9]
	wire eth_n_d       = !hit_eth; // [R9]
	wire lb_zero_n_d   = !hit_lb_zero; // [R9]
	wire lb_one_n_d    = !hit_lb_one; // [R9]
	wire lb_two_n_d    = !hit_lb_two; // [R9]
	wire lb_three_n_d  = !hit_lb_three; // [R9]
	wire disk_pri_n_d  = !hit_disk_pri; // [R9]
	wire disk_sec_n_d  = !hit_disk_sec; // [R9]

	logic nand_n_q;
	logic clock_n_q;
	logic eth_n_q;
	logic lb_zero_n_q;
	logic lb_one_n_q;
	logic lb_two_n_q;
	logic lb_three_n_q;
	logic disk_pri_n_q;
	logic disk_sec_n_q;

	// one flop per select keeps every output straight from a register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			nand_n_q <= mcsd_pkg::SEL_IDLE_N[0]; // [R9]
		end else begin
			nand_n_q <= nand_n_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			clock_n_q <= mcsd_pkg::SEL_IDLE_N[1]; // [R9]
		end else begin
			clock_n_q <= clock_n_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			eth_n_q <= mcsd_pkg::SEL_IDLE_N[2]; // [R9]
		end else begin
			eth_n_q <= eth_n_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lb_zero_n_q <= mcsd_pkg::SEL_IDLE_N[3]; // [R9]
		end else begin
			lb_zero_n_q <= lb_zero_n_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lb_one_n_q <= mcsd_pkg::SEL_IDLE_N[4]; // [R9]
		end else begin
			lb_one_n_q <= lb_one_n_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lb_two_n_q <= mcsd_pkg::SEL_IDLE_N[5]; // [R9]
		end else begin
			lb_two_n_q <= lb_two_n_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lb_three_n_q <= mcsd_pkg::SEL_IDLE_N[6]; // [R9]
		end else begin
			lb_three_n_q <= lb_three_n_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			disk_pri_n_q <= mcsd_pkg::SEL_IDLE_N[7]; // [R9]
		end else begin
			disk_pri_n_q <= disk_pri_n_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			disk_sec_n_q <= mcsd_pkg::SEL_IDLE_N[8]; // [R9]
		end else begin
			disk_sec_n_q <= disk_sec_n_d;
		end
	end

	assign nand_select_n            = nand_n_q;
	assign clock_chip_select_n      = clock_n_q;
	assign ethernet_select_n        = eth_n_q;
	assign local_bus_select_zero_n  = lb_zero_n_q;
	assign local_bus_select_one_n   = lb_one_n_q;
	assign local_bus_select_two_n   = lb_two_n_q;
	assign local_bus_select_three_n = lb_three_n_q;
	assign disk_primary_select_n    = disk_pri_n_q;
	assign disk_secondary_select_n  = disk_sec_n_q;
endmodule // mcsd_decoder

// [tb/mcsd_host.sv]
// mcsd_host: host side, turns a bus address into static selects.
// assumes the bench moves addr just after an edge; both_low forces an illegal cycle.
`timescale 1ns/100ps
module mcsd_host (
	input  wire logic [31:0] addr,
	input  wire logic        both_low,
	output logic             one_n,
	output logic             three_n,
	output logic [3:0]       ab
);
	assign one_n   = !both_low && addr[31:26] != mcsd_pkg::CS1_BASE[31:26];
	assign three_n = !both_low && addr[31:26] != mcsd_pkg::CS3_BASE[31:26];
	assign ab      = addr[25:22];
endmodule // mcsd_host

// [tb/mcsd_decoder_props.sv]
// checker: outputs against inputs seen three edges earlier.
// assumes it is bound into mcsd_decoder and sees only that module's ports.
`timescale 1ns/100ps
module mcsd_decoder_props (
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic       cpu_static_select_one_n,
	input wire logic       cpu_static_select_three_n,
	input wire logic [3:0] upper_address_bits,
	input wire logic       nand_select_n,
	input wire logic       clock_chip_select_n,
	input wire logic       ethernet_select_n,
	input wire logic       local_bus_select_zero_n,
	input wire logic       local_bus_select_one_n,
	input wire logic       local_bus_select_two_n,
	input wire logic       local_bus_select_three_n,
	input wire logic       disk_primary_select_n,
	input wire logic       disk_secondary_select_n
);
	logic [5:0] p1_q, p2_q, p3_q;
	logic [1:0] c_q;
	wire v = c_q == 2'h3, g1 = !p3_q[5] && p3_q[4], g3 = p3_q[5] && !p3_q[4];
	wire [3:0] a = p3_q[3:0];
	wire [8:0] s = {nand_select_n, clock_chip_select_n, ethernet_select_n, local_bus_select_zero_n,
		local_bus_select_one_n, local_bus_select_two_n, local_bus_select_three_n, disk_primary_select_n,
		disk_secondary_select_n};
	wire [8:0] e = ~{g1 && a == 4'h0, g1 && a == 4'h5, g1 && a == 4'h6, g3 && a == 4'h0, g3, g3 && a == 4'h4,
		g3 && a == 4'h6, g3 && a == 4'hC, g3 && a[3:1] == 3'h4};
	always_ff @(posedge clk_sys) begin
		p1_q <= {cpu_static_select_one_n, cpu_static_select_three_n, upper_address_bits};
		p2_q <= p1_q;
		p3_q <= p2_q;
		c_q <= reset ? 2'h0 : c_q + {1'h0, !v};
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_stable_in_out: assert property (v && p3_q == p2_q |=> $stable(s)) else $error("select moved");
	chk_onboard_codes: assert property (v |-> s[8:6] == e[8:6]) else $error("onboard select");
	chk_lbus_codes: assert property (v |-> {s[5], s[3:2]} == {e[5], e[3:2]}) else $error("local select");
	chk_lbus_one: assert property (v |-> s[4] == !g3) else $error("local one");
	chk_disk_primary: assert property (v |-> s[1] == e[1]) else $error("disk primary");
	chk_disk_secondary: assert property (v |-> s[0] == e[0]) else $error("disk secondary");
	chk_idle_high: assert property (v && !g1 && !g3 |-> s == 9'h1FF) else $error("not idle");
	cover property (v && !s[7]);
	cover property (v && !s[1]);
	cover property (v && !s[0]);
	cover property (v && !p3_q[5] && !p3_q[4]);
endmodule // mcsd_decoder_props
bind mcsd_decoder mcsd_decoder_props i_mcsd_decoder_props(.*);

// [tb/mcsd_decoder_tb.sv]
// mcsd_decoder_tb: every code in each region, both selects low, then random addresses.
// assumes the host model turns addresses into selects; the fixed seed makes runs repeatable.
`timescale 1ns/100ps
`define CK(n, e, s) begin \
	num_checks++; \
	if ((s) !== (e)) begin \
		num_errors++; \
		$display("Error %s exp %h got %h", n, e, s); \
	end \
end
module mcsd_decoder_tb;
	logic clk_sys = 0, reset = 1, cpu_static_select_one_n, cpu_static_select_three_n;
	logic [31:0] adr = 32'h0000_0000;
	logic both_low = 1'b0;
	logic [3:0] upper_address_bits;
	logic [8:0] y;
	int num_errors = 0, num_checks = 0, seed = 38525;
	always #2 clk_sys = ~clk_sys;
	mcsd_host i_mcsd_host(.addr(adr), .both_low(both_low), .one_n(cpu_static_select_one_n),
		.three_n(cpu_static_select_three_n),
		.ab(upper_address_bits));
	mcsd_decoder i_mcsd_decoder(.*, .nand_select_n(y[8]), .clock_chip_select_n(y[7]), .ethernet_select_n(y[6]),
		.local_bus_select_zero_n(y[5]), .local_bus_select_one_n(y[4]), .local_bus_select_two_n(y[3]),
		.local_bus_select_three_n(y[2]), .disk_primary_select_n(y[1]), .disk_secondary_select_n(y[0]));
	function logic [8:0] ex(logic [31:0] x, logic b);
		logic g1, g3;
		g1 = !b && x[31:26] == 6'h01;
		g3 = !b && x[31:26] == 6'h03;
		ex = ~{g1 && x[25:22] == 4'h0, g1 && x[25:22] == 4'h5, g1 && x[25:22] == 4'h6, g3 && x[25:22] == 4'h0, g3,
			g3 && x[25:22] == 4'h4, g3 && x[25:22] == 4'h6, g3 && x[25:22] == 4'hC, g3 && x[25:23] == 3'h4};
	endfunction
	task go(logic [31:0] x, logic b);
		@(posedge clk_sys) #1 adr = x;
		both_low = b;
		repeat (3) @(posedge clk_sys);
		#1 `CK("selects", ex(x, b), y)
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 reset = 0;
		for (int i = 0; i < 64; i++) go({4'h0, i[5:0], 22'h3F_FFFF}, 1'b0);
		for (int i = 0; i < 16; i++) go({6'h00, i[3:0], 22'h00_0000}, 1'b1);
		repeat (60) go($random(seed) & 32'h0FFF_FFFF, 1'b0);
		summarize;
	end
	initial begin
		#4000;
		num_errors++;
		summarize;
	end
endmodule // mcsd_decoder_tb
